// ---- hdl/sfp_cfg.svh ----
// constants for the flash protection and control command block
`ifndef SFP_CFG_SVH
`define SFP_CFG_SVH

`define SFP_OP_WR_ENABLE 8'h06
`define SFP_OP_WR_DISABLE 8'h04
`define SFP_OP_RD_STATUS1 8'h05
`define SFP_OP_WR_STATUS 8'h01
`define SFP_OP_PAGE_PROG 8'h02
`define SFP_OP_ERASE_4K 8'h20
`define SFP_OP_ERASE_32K 8'h52
`define SFP_OP_ERASE_64K 8'hD8
`define SFP_OP_CHIP_ERASE_A 8'h60
`define SFP_OP_CHIP_ERASE_B 8'hC7
`define SFP_OP_SEC_PROG 8'h42
`define SFP_OP_SEC_ERASE 8'h44
`define SFP_OP_RESET_ARM 8'h66
`define SFP_OP_RESET_GO 8'h99
`define SFP_OP_UNIQUE_ID 8'h4B

`define SFP_SR_BUSY 0
`define SFP_SR_WR_LATCH 1
`define SFP_SR_BP_LSB 2
`define SFP_SR_COMPLEMENT 7
`define SFP_NV_RESET 6'h00

`define SFP_BITS_OPCODE 8'h08
`define SFP_BITS_ONE_DATA 8'h10
`define SFP_BITS_TWO_DATA 8'h18
`define SFP_BITS_ADDR_END 8'h20
`define SFP_BITS_PROG_MIN 8'h28
`define SFP_UID_FIRST_CNT 8'h28
`define SFP_UID_LAST_CNT 8'h67
`define SFP_SEC_PAGE_LSB 12
`define SFP_PAGE_BITS 8
`define SFP_BLOCK_4K_BITS 12
`define SFP_BLOCK_32K_BITS 15
`define SFP_BLOCK_64K_BITS 16

`define SFP_CLK_PERIOD_NS 10
`define SFP_RECOVERY_NS 30000
`define SFP_RECOVERY_CYC \
   ((`SFP_RECOVERY_NS + `SFP_CLK_PERIOD_NS - 1) / `SFP_CLK_PERIOD_NS)

`endif

// ---- hdl/sfp_ctl.sv ----
// flash write protection, reset and unique-id command logic
// How it works
// - write-disable opcode clears the write enable latch when chip select rises.
// - program, erase, security program and status write need the latch set.
// - write-disable takes no address; extra serial input in its frame is ignored.
// - frames ending mid-opcode or off a byte boundary are dropped, latch unchanged.
// - complement and five block-protect bits are non-volatile, changed only by status write.
// - complement clear: protect code picks none, granularity, array end, fraction or all.
// - complement set protects exactly what the same code leaves open otherwise.
// - program or erase touching any protected address is ignored.
// - write-protect pin low blocks protect bit changes, never array access itself.
// - accepted reset clears latch, suspend flags, mode byte, wrap setting, aborts work.
// - reset needs reset-arm directly before it; any other command disarms.
// - after reset all commands are ignored for the recovery time.
// - three security pages, each erased, programmed and locked on its own.
// - unique-id: opcode, four dummy bytes, then 64 fixed bits on falling edges.
// - write-enable opcode sets the latch at chip select rise on a byte boundary.
// - status-1 read repeats status byte 1, msb first, while chip select low.
`include "sfp_cfg.svh"

module sfp_ctl #(
   parameter int AW = 19,
   parameter logic [63:0] UNIQUE_ID = 64'h0123_4567_89AB_CDEF // arbitrary
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic mosi,
   output logic miso,
   output logic miso_oe,
   input wire logic wp_n,
   input wire logic busy_in,
   input wire logic [2:0] sec_lock,
   input wire logic susp_upd,
   input wire logic susp_erase_d,
   input wire logic susp_prog_d,
   input wire logic mode_upd,
   input wire logic [7:0] mode_byte_d,
   input wire logic wrap_upd,
   input wire logic [2:0] wrap_d,
   output logic write_enable_latch,
   output logic protect_complement,
   output logic protect_granularity_sel,
   output logic protect_lower_upper_sel,
   output logic protect_size_bit2,
   output logic protect_size_bit1,
   output logic protect_size_bit0,
   output logic [AW-1:0] prot_lo,
   output logic [AW-1:0] prot_hi,
   output logic prot_none,
   output logic cmd_go,
   output sfp_pkg::sfp_cmd_t cmd_kind,
   output logic [AW-1:0] cmd_addr,
   output logic cmd_refused,
   output logic sw_reset,
   output logic reset_recovering,
   output logic erase_suspended_flag,
   output logic program_suspended_flag,
   output logic [7:0] continuous_read_mode_byte,
   output logic [2:0] wrap_length_setting
);

   localparam int RECOV_CYC = `SFP_RECOVERY_CYC;

   function automatic logic [AW-1:0] span_mask(input int unsigned bits);
      span_mask = AW'((32'h1 << bits) - 32'h1);
   endfunction

   // link side: serial shifter on the host clock
   logic first_q;
   logic tog_q;
   logic [7:0] cnt_q;
   logic [31:0] sh_q;
   logic got_op_q;
   logic [7:0] op_q;
   logic [AW-1:0] addr_q;
   logic [8:0] st_s1_q;
   logic [8:0] st_s2_q;
   logic miso_q;
   logic oe_q;

   // system side
   logic [2:0] cs_sync_q;
   logic cs_f_q;
   logic [2:0] wp_sync_q;
   logic wp_f_q;
   logic seen_q;
   sfp_pkg::sfp_state_t state_q;
   logic [11:0] recov_q;
   logic wel_q;
   logic armed_q;
   logic [5:0] nv_q;
   logic [8:0] status_q;
   logic [AW-1:0] dec_lo;
   logic [AW-1:0] dec_hi;
   logic dec_none;
   logic [AW-1:0] lo_q;
   logic [AW-1:0] hi_q;
   logic none_q;
   logic go_q;
   sfp_pkg::sfp_cmd_t kind_q;
   logic [AW-1:0] caddr_q;
   logic refused_q;
   logic rst_q;
   logic esus_q;
   logic psus_q;
   logic [7:0] mode_q;
   logic [2:0] wrap_q;

   // frame start flag is held set while chip select is high
   always_ff @(posedge sclk or posedge cs_n)
   begin
      if (cs_n)
         first_q <= 1'b1;
      else
         first_q <= 1'b0;
   end

   // shifter state stays stable after the frame for the system side to read
   always_ff @(posedge sclk or posedge srst)
   begin
      if (srst)
      begin
         tog_q <= 1'b0;
         cnt_q <= 8'h00;
         sh_q <= 32'h0000_0000;
         got_op_q <= 1'b0;
         op_q <= 8'h00;
         addr_q <= '0;
      end
      else
      begin
         tog_q <= tog_q ^ first_q;
         cnt_q <= first_q ? 8'h01 : cnt_q + 8'h01;
         sh_q <= {sh_q[30:0], mosi};
         if (first_q)
            got_op_q <= 1'b0;
         else if (cnt_q == `SFP_BITS_OPCODE - 8'h01)
            got_op_q <= 1'b1;
         if (!first_q && cnt_q == `SFP_BITS_OPCODE - 8'h01)
            op_q <= {sh_q[6:0], mosi};
         if (!first_q && cnt_q == `SFP_BITS_ADDR_END - 8'h01)
            addr_q <= {sh_q[AW-2:0], mosi};
      end
   end

   // status bits are independent levels, each takes two flops
   always_ff @(posedge sclk)
   begin
      st_s1_q <= status_q;
      st_s2_q <= st_s1_q;
   end

   // data out changes on falling edges, off whenever chip select is high
   always_ff @(negedge sclk or posedge cs_n)
   begin
      if (cs_n)
      begin
         miso_q <= 1'b0;
         oe_q <= 1'b0;
      end
      else if (first_q || !got_op_q || st_s2_q[8])
      begin
         miso_q <= 1'b0;
         oe_q <= 1'b0;
      end
      else if (op_q == `SFP_OP_RD_STATUS1)
      begin
         miso_q <= st_s2_q[~cnt_q[2:0]];
         oe_q <= 1'b1;
      end
      else if (op_q == `SFP_OP_UNIQUE_ID && cnt_q >= `SFP_UID_FIRST_CNT &&
               cnt_q <= `SFP_UID_LAST_CNT)
      begin
         miso_q <= UNIQUE_ID[6'(`SFP_UID_LAST_CNT - cnt_q)];
         oe_q <= 1'b1;
      end
      else
      begin
         miso_q <= 1'b0;
         oe_q <= 1'b0;
      end
   end

   // pins pass three flops; a change counts when the last two agree
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         cs_sync_q <= 3'h7;
         cs_f_q <= 1'b1;
         wp_sync_q <= 3'h0;
         wp_f_q <= 1'b0;
      end
      else
      begin
         cs_sync_q <= {cs_sync_q[1:0], cs_n};
         if (cs_sync_q[1] == cs_sync_q[2])
            cs_f_q <= cs_sync_q[2];
         wp_sync_q <= {wp_sync_q[1:0], wp_n};
         if (wp_sync_q[1] == wp_sync_q[2])
            wp_f_q <= wp_sync_q[2];
      end
   end

   // frame decode, valid in the cycle chip select is seen to rise
   logic frame_end;
   logic frame_ok;
   logic new_frame;
   logic is_write;
   logic is_sec;
   logic len_ok;
   logic page_ok;
   logic hit;
   logic [AW-1:0] blk_lo;
   logic [AW-1:0] blk_hi;
   logic [7:0] sr_byte;
   sfp_pkg::sfp_cmd_t kind_d;

   always_comb
   begin
      logic [AW-1:0] m;
      m = '0;
      frame_end = cs_sync_q[1] && cs_sync_q[2] && !cs_f_q;
      new_frame = frame_end && (tog_q != seen_q);
      frame_ok = new_frame && got_op_q && (cnt_q[2:0] == 3'h0) &&
                 state_q == sfp_pkg::SFP_ST_IDLE;
      is_write = 1'b1;
      is_sec = 1'b0;
      len_ok = 1'b0;
      kind_d = sfp_pkg::SFP_CMD_PAGE_PROG;
      unique case (op_q)
         `SFP_OP_PAGE_PROG:
         begin
            m = span_mask(`SFP_PAGE_BITS);
            len_ok = cnt_q >= `SFP_BITS_PROG_MIN;
         end
         `SFP_OP_ERASE_4K:
         begin
            m = span_mask(`SFP_BLOCK_4K_BITS);
            len_ok = cnt_q == `SFP_BITS_ADDR_END;
            kind_d = sfp_pkg::SFP_CMD_ERASE_4K;
         end
         `SFP_OP_ERASE_32K:
         begin
            m = span_mask(`SFP_BLOCK_32K_BITS);
            len_ok = cnt_q == `SFP_BITS_ADDR_END;
            kind_d = sfp_pkg::SFP_CMD_ERASE_32K;
         end
         `SFP_OP_ERASE_64K:
         begin
            m = span_mask(`SFP_BLOCK_64K_BITS);
            len_ok = cnt_q == `SFP_BITS_ADDR_END;
            kind_d = sfp_pkg::SFP_CMD_ERASE_64K;
         end
         `SFP_OP_CHIP_ERASE_A, `SFP_OP_CHIP_ERASE_B:
         begin
            m = '1;
            len_ok = cnt_q == `SFP_BITS_OPCODE;
            kind_d = sfp_pkg::SFP_CMD_CHIP_ERASE;
         end
         `SFP_OP_SEC_PROG:
         begin
            is_sec = 1'b1;
            len_ok = cnt_q >= `SFP_BITS_PROG_MIN;
            kind_d = sfp_pkg::SFP_CMD_SEC_PROG;
         end
         `SFP_OP_SEC_ERASE:
         begin
            is_sec = 1'b1;
            len_ok = cnt_q == `SFP_BITS_ADDR_END;
            kind_d = sfp_pkg::SFP_CMD_SEC_ERASE;
         end
         default:
            is_write = 1'b0;
      endcase
      blk_lo = addr_q & ~m;
      blk_hi = addr_q | m;
      hit = !none_q && blk_lo <= hi_q && blk_hi >= lo_q;
      // security pages sit apart from the array and have their own locks
      page_ok = addr_q[AW-1:16] == '0 &&
                addr_q[15:`SFP_SEC_PAGE_LSB] >= 4'h1 &&
                addr_q[15:`SFP_SEC_PAGE_LSB] <= 4'h3 &&
                !sec_lock[addr_q[13:12] - 2'h1];
      sr_byte = (cnt_q == `SFP_BITS_ONE_DATA) ? sh_q[7:0] : sh_q[15:8];
   end

   logic do_reset;
   assign do_reset = frame_ok && op_q == `SFP_OP_RESET_GO && armed_q;

   always_ff @(posedge clk)
   begin
      if (srst)
         seen_q <= 1'b0;
      else if (new_frame)
         seen_q <= tog_q;
   end

   // recovery window after an accepted reset
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         state_q <= sfp_pkg::SFP_ST_IDLE;
         recov_q <= 12'h000;
      end
      else
      begin
         unique case (state_q)
            sfp_pkg::SFP_ST_IDLE:
               if (do_reset)
               begin
                  state_q <= sfp_pkg::SFP_ST_RECOVER;
                  recov_q <= 12'(RECOV_CYC - 1);
               end
            sfp_pkg::SFP_ST_RECOVER:
               if (recov_q == 12'h000)
                  state_q <= sfp_pkg::SFP_ST_IDLE;
               else
                  recov_q <= recov_q - 12'h001;
         endcase
      end
   end

   always_ff @(posedge clk)
   begin
      if (srst)
         armed_q <= 1'b0;
      else if (frame_ok)
         armed_q <= op_q == `SFP_OP_RESET_ARM;
   end

   // write enable latch; write commands consume it when launched or refused
   always_ff @(posedge clk)
   begin
      if (srst || do_reset)
         wel_q <= 1'b0;
      else if (frame_ok)
      begin
         if (op_q == `SFP_OP_WR_ENABLE)
            wel_q <= 1'b1;
         else if (op_q == `SFP_OP_WR_DISABLE)
            wel_q <= 1'b0;
         else if (op_q == `SFP_OP_WR_STATUS && wel_q)
            wel_q <= 1'b0;
         else if (is_write && wel_q)
            wel_q <= 1'b0;
      end
   end

   // protect bits survive software reset; write-protect pin freezes them
   always_ff @(posedge clk)
   begin
      if (srst)
         nv_q <= `SFP_NV_RESET;
      else if (frame_ok && op_q == `SFP_OP_WR_STATUS && wel_q && wp_f_q &&
               (cnt_q == `SFP_BITS_ONE_DATA ||
                cnt_q == `SFP_BITS_TWO_DATA))
         nv_q <= {sr_byte[`SFP_SR_COMPLEMENT],
                  sr_byte[`SFP_SR_BP_LSB+4:`SFP_SR_BP_LSB]};
   end

   sfp_prot_range #(
      .AW(AW)
   ) u_range (
      .cmp(nv_q[5]),
      .bp(nv_q[4:0]),
      .lo(dec_lo),
      .hi(dec_hi),
      .none(dec_none)
   );

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         lo_q <= '0;
         hi_q <= '0;
         none_q <= 1'b1;
      end
      else
      begin
         lo_q <= dec_lo;
         hi_q <= dec_hi;
         none_q <= dec_none;
      end
   end

   // launch or refuse program and erase commands
   always_ff @(posedge clk)
   begin
      if (srst || do_reset)
      begin
         go_q <= 1'b0;
         refused_q <= 1'b0;
         kind_q <= sfp_pkg::SFP_CMD_PAGE_PROG;
         caddr_q <= '0;
      end
      else
      begin
         go_q <= 1'b0;
         refused_q <= 1'b0;
         if (frame_ok && is_write && wel_q)
         begin
            if (!len_ok || (is_sec ? !page_ok : hit))
               refused_q <= 1'b1;
            else
            begin
               go_q <= 1'b1;
               kind_q <= kind_d;
               caddr_q <= addr_q;
            end
         end
      end
   end

   always_ff @(posedge clk)
   begin
      if (srst)
         rst_q <= 1'b0;
      else
         rst_q <= do_reset;
   end

   // volatile settings owned here so a reset clears them in one place
   always_ff @(posedge clk)
   begin
      if (srst || do_reset)
      begin
         esus_q <= 1'b0;
         psus_q <= 1'b0;
         mode_q <= 8'h00;
         wrap_q <= 3'h0;
      end
      else
      begin
         if (susp_upd)
         begin
            esus_q <= susp_erase_d;
            psus_q <= susp_prog_d;
         end
         if (mode_upd)
            mode_q <= mode_byte_d;
         if (wrap_upd)
            wrap_q <= wrap_d;
      end
   end

   // recovering bit rides along so the link side stays silent too
   always_ff @(posedge clk)
   begin
      if (srst)
         status_q <= 9'h000;
      else
         status_q <= {state_q == sfp_pkg::SFP_ST_RECOVER, nv_q, wel_q,
                      busy_in || state_q == sfp_pkg::SFP_ST_RECOVER};
   end

   assign miso = miso_q;
   assign miso_oe = oe_q;
   assign write_enable_latch = wel_q;
   assign protect_complement = nv_q[5];
   assign protect_granularity_sel = nv_q[4];
   assign protect_lower_upper_sel = nv_q[3];
   assign protect_size_bit2 = nv_q[2];
   assign protect_size_bit1 = nv_q[1];
   assign protect_size_bit0 = nv_q[0];
   assign prot_lo = lo_q;
   assign prot_hi = hi_q;
   assign prot_none = none_q;
   assign cmd_go = go_q;
   assign cmd_kind = kind_q;
   assign cmd_addr = caddr_q;
   assign cmd_refused = refused_q;
   assign sw_reset = rst_q;
   assign reset_recovering = state_q == sfp_pkg::SFP_ST_RECOVER;
   assign erase_suspended_flag = esus_q;
   assign program_suspended_flag = psus_q;
   assign continuous_read_mode_byte = mode_q;
   assign wrap_length_setting = wrap_q;

endmodule // sfp_ctl

// ---- hdl/sfp_pkg.sv ----
// types shared by the flash protection and control command block
package sfp_pkg;

   typedef enum logic [2:0]
   {
      SFP_CMD_PAGE_PROG = 3'h0,
      SFP_CMD_ERASE_4K = 3'h1,
      SFP_CMD_ERASE_32K = 3'h2,
      SFP_CMD_ERASE_64K = 3'h3,
      SFP_CMD_CHIP_ERASE = 3'h4,
      SFP_CMD_SEC_PROG = 3'h5,
      SFP_CMD_SEC_ERASE = 3'h6
   } sfp_cmd_t;

   typedef enum logic [0:0]
   {
      SFP_ST_IDLE = 1'b0,
      SFP_ST_RECOVER = 1'b1
   } sfp_state_t;

endpackage

// ---- hdl/sfp_prot_range.sv ----
// decode of protect complement and block-protect code into an address range
`include "sfp_cfg.svh"

module sfp_prot_range #(
   parameter int AW = 19
) (
   input wire logic cmp,
   input wire logic [4:0] bp,
   output logic [AW-1:0] lo,
   output logic [AW-1:0] hi,
   output logic none
);

   always_comb
   begin
      logic [AW-1:0] size;
      logic [AW-1:0] top;
      logic [AW-1:0] blo;
      logic [AW-1:0] bhi;
      logic bnone;
      logic ball;
      size = '0;
      top = '1;
      bnone = 1'b0;
      ball = 1'b0;
      blo = '0;
      bhi = '0;
      if (bp[2:0] == 3'h0)
         bnone = 1'b1;
      else if (!bp[4])
      begin
         if (bp[2])
            ball = 1'b1;
         else
            size = AW'(32'h10000) << (bp[1:0] - 2'h1);
      end
      else
      begin
         if (bp[2:0] == 3'h7)
            ball = 1'b1;
         else if (bp[2])
            size = AW'(32'h8000);
         else
            size = AW'(32'h1000) << (bp[1:0] - 2'h1);
      end
      // ranges always close on the array top or just below a size step
      if (bp[3])
      begin
         blo = '0;
         bhi = size - AW'(1);
      end
      else
      begin
         blo = top - size + AW'(1);
         bhi = top;
      end
      if (ball)
      begin
         blo = '0;
         bhi = top;
      end
      if (!cmp)
      begin
         lo = blo;
         hi = bhi;
         none = bnone;
      end
      else if (bnone)
      begin
         lo = '0;
         hi = top;
         none = 1'b0;
      end
      else if (ball)
      begin
         lo = '0;
         hi = '0;
         none = 1'b1;
      end
      else if (bp[3])
      begin
         lo = bhi + AW'(1);
         hi = top;
         none = 1'b0;
      end
      else
      begin
         lo = '0;
         hi = blo - AW'(1);
         none = 1'b0;
      end
   end

endmodule // sfp_prot_range

// ---- tb/sfp_ctl_assertions.sv ----
// port-level checks for the flash protection and control block
module sfp_ctl_assertions #(
   parameter int AW = 19
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic cs_n,
   input wire logic wp_n,
   input wire logic miso_oe,
   input wire logic write_enable_latch,
   input wire logic protect_complement,
   input wire logic protect_granularity_sel,
   input wire logic protect_lower_upper_sel,
   input wire logic protect_size_bit2,
   input wire logic protect_size_bit1,
   input wire logic protect_size_bit0,
   input wire logic [AW-1:0] prot_lo,
   input wire logic [AW-1:0] prot_hi,
   input wire logic prot_none,
   input wire logic cmd_go,
   input wire sfp_pkg::sfp_cmd_t cmd_kind,
   input wire logic [AW-1:0] cmd_addr,
   input wire logic cmd_refused,
   input wire logic sw_reset,
   input wire logic reset_recovering,
   input wire logic erase_suspended_flag,
   input wire logic program_suspended_flag,
   input wire logic [7:0] continuous_read_mode_byte,
   input wire logic [2:0] wrap_length_setting
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   wire logic [5:0] bits = {protect_complement, protect_granularity_sel,
      protect_lower_upper_sel, protect_size_bit2, protect_size_bit1,
      protect_size_bit0};
   wire logic all_c = bits[2:0] == 3'h7 || (!bits[4] && bits[2]);
   wire logic none_e = bits[5] ? all_c : bits[2:0] == 3'h0;
   logic [12:0] rec_cnt_q;
   always_ff @(posedge clk)
   begin
      if (srst || !reset_recovering)
         rec_cnt_q <= 13'h0000;
      else
         rec_cnt_q <= rec_cnt_q + 13'h0001;
   end
   property p_go_latch;
      cmd_go |-> $past(write_enable_latch) && !write_enable_latch;
   endproperty
   a_go_latch: assert property (p_go_latch)
      else $error("launch without write enable latch");
   property p_go_outside;
      cmd_go && cmd_kind < sfp_pkg::SFP_CMD_SEC_PROG |-> prot_none ||
         (cmd_kind != sfp_pkg::SFP_CMD_CHIP_ERASE &&
         (cmd_addr < prot_lo || cmd_addr > prot_hi));
   endproperty
   a_go_outside: assert property (p_go_outside)
      else $error("launch touches protected range");
   property p_recover_quiet;
      reset_recovering && $past(reset_recovering) |->
         !cmd_go && !sw_reset && $stable(write_enable_latch);
   endproperty
   a_recover_quiet: assert property (p_recover_quiet)
      else $error("command acted during recovery");
   property p_recover_len;
      $fell(reset_recovering) |->
         rec_cnt_q >= 13'h0BB7 && rec_cnt_q <= 13'h0BBA;
   endproperty
   a_recover_len: assert property (p_recover_len)
      else $error("recovery window length wrong");
   property p_reset_clears;
      sw_reset |=> !write_enable_latch && !erase_suspended_flag &&
         !program_suspended_flag && continuous_read_mode_byte == 8'h00 &&
         wrap_length_setting == 3'h0 && reset_recovering;
   endproperty
   a_reset_clears: assert property (p_reset_clears)
      else $error("reset left volatile state");
   // wp_n passes a synchroniser, so allow settling before the lock holds
   property p_wp_lock;
      (!wp_n)[*6] |=> $stable(bits);
   endproperty
   a_wp_lock: assert property (p_wp_lock)
      else $error("protect bits changed with wp low");
   property p_nv_frame;
      $changed(bits) |-> $past(cs_n) && $past(cs_n, 2) && $past(cs_n, 3);
   endproperty
   a_nv_frame: assert property (p_nv_frame)
      else $error("protect bits changed inside a frame");
   property p_latch_frame;
      $changed(write_enable_latch) |-> $past(cs_n, 2) && $past(cs_n, 3);
   endproperty
   a_latch_frame: assert property (p_latch_frame)
      else $error("latch changed before frame end");
   property p_oe_idle;
      cs_n[*3] |-> !miso_oe;
   endproperty
   a_oe_idle: assert property (p_oe_idle)
      else $error("miso driven while deselected");
   property p_none;
      $stable(bits) && $past(bits) == $past(bits, 2) &&
         $past(bits, 2) == $past(bits, 3) |-> prot_none == none_e;
   endproperty
   a_none: assert property (p_none)
      else $error("empty range flag wrong");
   c_go: cover property (cmd_go);
   c_ref: cover property (cmd_refused);
   c_rst: cover property (sw_reset ##1 reset_recovering);
endmodule // sfp_ctl_assertions

bind sfp_ctl sfp_ctl_assertions #(.AW(AW)) u_chk (.*);

// ---- tb/sfp_ctl_tb.sv ----
// self-checking bench for the flash protection and control block
module sfp_ctl_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [63:0] UID = 64'h5A5A_0F0F_C3C3_9696; // arbitrary
   logic clk = 1'b0;
   logic srst = 1'b0;
   logic sclk, cs_n, mosi, miso, miso_oe;
   logic wp_n = 1'b1;
   logic busy_in = 1'b0;
   logic [2:0] sec_lock = 3'h0;
   logic susp_upd = 1'b0, susp_erase_d = 1'b0, susp_prog_d = 1'b0;
   logic mode_upd = 1'b0, wrap_upd = 1'b0;
   logic [7:0] mode_byte_d = 8'h00;
   logic [2:0] wrap_d = 3'h0;
   logic write_enable_latch, protect_complement, protect_granularity_sel;
   logic protect_lower_upper_sel, protect_size_bit2, protect_size_bit1;
   logic protect_size_bit0, prot_none, cmd_go, cmd_refused, sw_reset;
   logic reset_recovering, erase_suspended_flag, program_suspended_flag;
   logic [18:0] prot_lo, prot_hi, cmd_addr;
   sfp_pkg::sfp_cmd_t cmd_kind;
   logic [7:0] continuous_read_mode_byte;
   logic [2:0] wrap_length_setting;
   logic [103:0] rx;
   int err_total = 0, checks_done = 0, n_go = 0, n_ref = 0, n_rst = 0;
   wire logic [5:0] bits = {protect_complement, protect_granularity_sel,
      protect_lower_upper_sel, protect_size_bit2, protect_size_bit1,
      protect_size_bit0};
   logic [5:0] tc [8] = '{6'h01, 6'h0A, 6'h11, 6'h1D, 6'h0C, 6'h21,
      6'h37, 6'h39};
   logic [18:0] tlo [8] = '{19'h70000, 19'h00000, 19'h7F000, 19'h00000,
      19'h00000, 19'h00000, 19'h00000, 19'h01000};
   logic [18:0] thi [8] = '{19'h7FFFF, 19'h1FFFF, 19'h7FFFF, 19'h07FFF,
      19'h7FFFF, 19'h6FFFF, 19'h00000, 19'h7FFFF};

   always #5 clk = ~clk;

   sfp_ctl #(.AW(19), .UNIQUE_ID(UID)) dut (.*);
   sfp_host_model host (.sclk, .cs_n, .mosi, .miso);

   always @(posedge clk)
   begin
      n_go += (cmd_go === 1'b1);
      n_ref += (cmd_refused === 1'b1);
      n_rst += (sw_reset === 1'b1);
   end

   task automatic chk(input string nm, input logic [63:0] e,
      input logic [63:0] g);
      checks_done++;
      if (g !== e)
      begin
         err_total++;
         $display("BAD %s exp %0h got %0h", nm, e, g);
      end
   endtask

   // the model's idle gap already covers the 4-5 clk effect delay
   task automatic fr(input logic [103:0] tx, input int n);
      host.xfer(tx, n, rx);
      @(posedge clk);
      #1;
   endtask

   task automatic wrsr(input logic [5:0] c);
      fr(8'h06, 8);
      fr({8'h01, c, 2'b00}, 16);
   endtask

   task automatic close_out;
      $display("checks %0d errors %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   initial
   begin
      #1_000_000;
      err_total++;
      close_out();
   end

   initial
   begin
      // a real rising edge so the link side's async reset fires
      #1 srst = 1'b1;
      repeat (6) @(posedge clk);
      #1 srst = 1'b0;
      repeat (4) @(posedge clk);
      #1;
      chk("wel", 0, write_enable_latch);
      chk("bits", 0, bits);
      chk("none", 1, prot_none);
      fr(8'h06, 8);
      chk("wel", 1, write_enable_latch);
      fr(16'h04A5, 16);
      chk("wel", 0, write_enable_latch);
      fr(7'h03, 7);
      fr(12'h06F, 12);
      chk("wel", 0, write_enable_latch);
      fr(8'h06, 8);
      fr(12'h04F, 12);
      chk("wel", 1, write_enable_latch);
      fr(8'h04, 8);
      fr({8'h02, 24'h000100, 8'hAA}, 40);
      fr({8'h01, 8'h04}, 16);
      chk("go", 0, n_go);
      chk("bits", 0, bits);
      for (int i = 0; i < 8; i++)
      begin
         wrsr(tc[i]);
         chk("bits", tc[i], bits);
         chk("wel", 0, write_enable_latch);
         chk("none", i == 6, prot_none);
         if (i != 6)
         begin
            chk("lo", tlo[i], prot_lo);
            chk("hi", thi[i], prot_hi);
         end
      end
      wrsr(6'h01);
      fr(8'h06, 8);
      fr({8'h02, 24'h06FF00, 8'h5A}, 40);
      chk("go", 1, n_go);
      chk("kind", sfp_pkg::SFP_CMD_PAGE_PROG, cmd_kind);
      chk("addr", 19'h6FF00, cmd_addr);
      fr(8'h06, 8);
      fr({8'h20, 24'h070000}, 32);
      chk("ref", 1, n_ref);
      fr(8'h06, 8);
      fr({8'hD8, 24'h060000}, 32);
      chk("kind", sfp_pkg::SFP_CMD_ERASE_64K, cmd_kind);
      fr(8'h06, 8);
      fr(8'hC7, 8);
      chk("ref", 2, n_ref);
      sec_lock = 3'h2;
      fr(8'h06, 8);
      fr({8'h42, 24'h001000, 8'h11}, 40);
      chk("kind", sfp_pkg::SFP_CMD_SEC_PROG, cmd_kind);
      fr(8'h06, 8);
      fr({8'h44, 24'h002000}, 32);
      chk("go", 3, n_go);
      chk("ref", 3, n_ref);
      wp_n = 1'b0;
      wrsr(6'h00);
      chk("bits", 6'h01, bits);
      chk("wel", 0, write_enable_latch);
      wp_n = 1'b1;
      fr(8'h06, 8);
      fr({8'h05, 16'h0000}, 24);
      chk("status", 16'h0606, rx[15:0]);
      fr({8'h4B, 96'h0}, 104);
      chk("uid", UID, rx[63:0]);
      @(posedge clk);
      #1 {susp_upd, mode_upd, wrap_upd} = 3'h7;
      {susp_erase_d, susp_prog_d, mode_byte_d, wrap_d} = 13'h1F4D;
      @(posedge clk);
      #1 {susp_upd, mode_upd, wrap_upd} = 3'h0;
      chk("mode", 13'h1F4D, {erase_suspended_flag, program_suspended_flag,
         continuous_read_mode_byte, wrap_length_setting});
      fr(8'h66, 8);
      fr(8'h06, 8);
      fr(8'h99, 8);
      chk("rst", 0, n_rst);
      fr(8'h66, 8);
      fr(8'h99, 8);
      chk("rst", 1, n_rst);
      chk("vol", 0, {write_enable_latch, erase_suspended_flag,
         program_suspended_flag, continuous_read_mode_byte,
         wrap_length_setting});
      chk("bits", 6'h01, bits);
      fr(8'h06, 8);
      chk("wel", 0, write_enable_latch);
      repeat (3000) @(posedge clk);
      #1;
      chk("recov", 0, reset_recovering);
      fr(8'h06, 8);
      chk("wel", 1, write_enable_latch);
      close_out();
   end
endmodule // sfp_ctl_tb

// ---- tb/sfp_host_model.sv ----
// host spi controller model, mode 0, msb first
module sfp_host_model (
   output logic sclk,
   output logic cs_n,
   output logic mosi,
   input wire logic miso
);
   timeunit 1ns;
   timeprecision 1ps;
   initial
   begin
      sclk = 1'b0;
      mosi = 1'b1;
      // a real edge so the link side's async clears fire at start
      #1 cs_n = 1'b1;
   end
   // clock stands still outside frames; the bench picks n, so odd
   // lengths are only ever sent on purpose
   task automatic xfer(input logic [103:0] tx, input int n,
      output logic [103:0] rx);
      rx = '0;
      #7 cs_n = 1'b0;
      for (int i = n - 1; i >= 0; i--)
      begin
         mosi = tx[i];
         #32 sclk = 1'b1;
         rx = {rx[102:0], miso};
         #32 sclk = 1'b0;
      end
      #32 cs_n = 1'b1;
      mosi = ~mosi; // released line must not look valid
      #200;
   endtask
endmodule // sfp_host_model
